// [verilog/l2mc_regs.sv]
`timescale 1ns/1ns
`include "l2mc_consts.svh"

module l2mc_regs #(
    parameter int NUM_CORES = 4
) (
    input  wire logic        CORE_CLK_I,
    input  wire logic        NRST_I,
    input  wire logic        ACC_VALID_I,
    input  wire logic        ACC_WRITE_I,
    input  wire logic        ACC_SEL_I,
    input  wire logic [1:0]  ACC_EL_I,
    input  wire logic [31:0] ACC_WDATA_I,
    input  wire logic        AUX_CONTROL_LEVEL3_I,
    input  wire logic        AUX_CONTROL_LEVEL2_I,
    input  wire logic        NONSECURE_STATE_BIT_I,
    input  wire logic        RST_DISABLE_I,
    input  wire logic        ECC_DOUBLE_ERR_I,
    input  wire logic        AXI_ASYNC_ERR_I,
    input  wire logic        RAM_IDLE_I,
    input  wire logic        TIMER_TICK_I,
    output logic             ACC_DONE_O,
    output logic [31:0]      ACC_RDATA_O,
    output logic             ACC_TRAP_O,
    output logic [1:0]       ACC_TRAP_EL_O,
    output logic [3:0]       FLUSH_INC_O,
    output logic             PF_FULL_DIS_O,
    output logic             PF_DIS_O,
    output logic             EVICT_DIS_O,
    output logic             ECC_DIS_O,
    output logic             DCACHE_DIS_O,
    output logic [3:0]       TAG_SETUP_CYC_O,
    output logic [3:0]       TAG_READ_CYC_O,
    output logic [3:0]       TAG_WRITE_CYC_O,
    output logic [3:0]       DAT_SETUP_CYC_O,
    output logic [3:0]       DAT_READ_CYC_O,
    output logic [3:0]       DAT_WRITE_CYC_O,
    output logic             LIGHT_SLEEP_O,
    output logic             RETENTION_O
);

    // ==========================================================
    // Elaboration checks
    if (NUM_CORES < 1 || NUM_CORES > 4) begin : g_bad_cores
        $error("NUM_CORES must be 1 to 4");
    end

    localparam logic [1:0] CORE_CODE = 2'(NUM_CORES - 1);

    // ==========================================================
    // Helpers
    function automatic logic [3:0] plus_one(input logic [2:0] v);
        return {1'b0, v} + 4'h1;
    endfunction : plus_one

    // EL1 writes only if every level above lets it through; EL0 never writes, EL2 and EL3 always do
    function automatic logic write_ok(input logic [1:0] el, input logic a3, input logic a2,
                                      input logic ns);
        if (el == l2mc_pkg::L2MC_EL0) begin
            return 1'b0;
        end else if (el == l2mc_pkg::L2MC_EL1) begin
            return a3 && (a2 || !ns);
        end
        return 1'b1;
    endfunction : write_ok

    // Lowest refusing level wins when both refuse
    function automatic logic [1:0] trap_level(input logic [1:0] el, input logic a2, input logic ns);
        if (el == l2mc_pkg::L2MC_EL0) begin
            return l2mc_pkg::L2MC_EL1;
        end else if (ns && !a2) begin
            return l2mc_pkg::L2MC_EL2;
        end
        return l2mc_pkg::L2MC_EL3;
    endfunction : trap_level

    function automatic logic [`L2MC_CNT_W-1:0] sleep_limit(input logic [1:0] code);
        case (code)
            2'h0:    return '0;
            2'h1:    return `L2MC_SLEEP_16;
            default: return `L2MC_SLEEP_32;
        endcase
    endfunction : sleep_limit

    function automatic logic [`L2MC_CNT_W-1:0] ret_limit(input logic [2:0] code);
        case (code)
            3'h1:    return `L2MC_RET_2;
            3'h2:    return `L2MC_RET_8;
            3'h3:    return `L2MC_RET_32;
            3'h4:    return `L2MC_RET_64;
            3'h5:    return `L2MC_RET_128;
            3'h6:    return `L2MC_RET_256;
            3'h7:    return `L2MC_RET_512;
            default: return '0;
        endcase
    endfunction : ret_limit

    // ==========================================================
    // Access decode
    logic        rst_dis_meta;
    logic        rst_dis;
    logic        permit;
    logic        wr_main;
    logic        wr_ext;
    logic        clr_ecc;
    logic        clr_axi;
    logic [2:0]  lat [6];
    logic        ecc_flag;
    logic        axi_flag;
    logic [1:0]  sleep_sel;
    logic [2:0]  ret_sel;
    logic [31:0] main_word;
    logic [31:0] ext_word;

    assign permit  = write_ok(ACC_EL_I, AUX_CONTROL_LEVEL3_I, AUX_CONTROL_LEVEL2_I,
                              NONSECURE_STATE_BIT_I);
    // Security state is not part of the decode: one shared copy
    assign wr_main = ACC_VALID_I && ACC_WRITE_I && permit && (ACC_SEL_I == l2mc_pkg::L2MC_SEL_MAIN);
    assign wr_ext  = ACC_VALID_I && ACC_WRITE_I && permit && (ACC_SEL_I == l2mc_pkg::L2MC_SEL_EXT);
    assign clr_ecc = wr_ext && !ACC_WDATA_I[`L2MC_ECC_ERR_BIT];
    assign clr_axi = wr_ext && !ACC_WDATA_I[`L2MC_AXI_ERR_BIT];

    // ==========================================================
    // Strap pin synchroniser
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rst_dis_meta <= 1'b0;
            rst_dis      <= 1'b0;
        end else begin
            rst_dis_meta <= RST_DISABLE_I;
            rst_dis      <= rst_dis_meta;
        end
    end

    // ==========================================================
    // Main control storage
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            FLUSH_INC_O   <= `L2MC_FLUSH_RST;
            PF_FULL_DIS_O <= `L2MC_BIT_RST;
            PF_DIS_O      <= `L2MC_BIT_RST;
            EVICT_DIS_O   <= `L2MC_BIT_RST;
            ECC_DIS_O     <= `L2MC_BIT_RST;
            DCACHE_DIS_O  <= `L2MC_BIT_RST;
        end else if (wr_main) begin
            FLUSH_INC_O   <= ACC_WDATA_I[`L2MC_FLUSH_MSB:`L2MC_FLUSH_LSB];
            PF_FULL_DIS_O <= ACC_WDATA_I[`L2MC_PF_FULL_BIT];
            PF_DIS_O      <= ACC_WDATA_I[`L2MC_PF_DIS_BIT];
            EVICT_DIS_O   <= ACC_WDATA_I[`L2MC_EVICT_DIS_BIT];
            ECC_DIS_O     <= ACC_WDATA_I[`L2MC_ECC_DIS_BIT];
            // Multi-cluster use relies on software leaving this clear
            DCACHE_DIS_O  <= ACC_WDATA_I[`L2MC_DC_DIS_BIT];
        end
    end

    // Six latency fields: tag setup/read/write, data setup/read/write
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            for (int i = 0; i < 6; i++) begin
                lat[i] <= `L2MC_LAT_RST;
            end
        end else if (wr_main) begin
            lat[0] <= ACC_WDATA_I[`L2MC_TAG_SETUP_LSB +: `L2MC_LAT_W];
            lat[1] <= ACC_WDATA_I[`L2MC_TAG_READ_LSB +: `L2MC_LAT_W];
            lat[2] <= ACC_WDATA_I[`L2MC_TAG_WRITE_LSB +: `L2MC_LAT_W];
            lat[3] <= ACC_WDATA_I[`L2MC_DAT_SETUP_LSB +: `L2MC_LAT_W];
            lat[4] <= ACC_WDATA_I[`L2MC_DAT_READ_LSB +: `L2MC_LAT_W];
            lat[5] <= ACC_WDATA_I[`L2MC_DAT_WRITE_LSB +: `L2MC_LAT_W];
        end
    end

    // Cycle counts handed to the RAM sequencer
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            TAG_SETUP_CYC_O <= `L2MC_CYC_RST;
            TAG_READ_CYC_O  <= `L2MC_CYC_RST;
            TAG_WRITE_CYC_O <= `L2MC_CYC_RST;
            DAT_SETUP_CYC_O <= `L2MC_CYC_RST;
            DAT_READ_CYC_O  <= `L2MC_CYC_RST;
            DAT_WRITE_CYC_O <= `L2MC_CYC_RST;
        end else begin
            TAG_SETUP_CYC_O <= plus_one(lat[0]);
            TAG_READ_CYC_O  <= plus_one(lat[1]);
            TAG_WRITE_CYC_O <= plus_one(lat[2]);
            DAT_SETUP_CYC_O <= plus_one(lat[3]);
            DAT_READ_CYC_O  <= plus_one(lat[4]);
            DAT_WRITE_CYC_O <= plus_one(lat[5]);
        end
    end

    // ==========================================================
    // Extended control storage
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sleep_sel <= `L2MC_SLEEP_RST;
            ret_sel   <= `L2MC_RET_RST;
        end else if (wr_ext) begin
            sleep_sel <= ACC_WDATA_I[`L2MC_SLEEP_MSB:`L2MC_SLEEP_LSB];
            ret_sel   <= ACC_WDATA_I[`L2MC_RET_MSB:`L2MC_RET_LSB];
        end
    end

    // Error in the same cycle as a clear still lands
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ecc_flag <= 1'b0;
            axi_flag <= 1'b0;
        end else begin
            ecc_flag <= ECC_DOUBLE_ERR_I || (ecc_flag && !clr_ecc);
            axi_flag <= AXI_ASYNC_ERR_I || (axi_flag && !clr_axi);
        end
    end

    // ==========================================================
    // Read words; everything not placed is zero
    always_comb begin
        main_word = '0;
        main_word[`L2MC_RSTDIS_BIT] = rst_dis;
        main_word[`L2MC_FLUSH_MSB:`L2MC_FLUSH_LSB] = FLUSH_INC_O;
        main_word[`L2MC_CORES_MSB:`L2MC_CORES_LSB] = CORE_CODE;
        main_word[`L2MC_PF_FULL_BIT] = PF_FULL_DIS_O;
        main_word[`L2MC_PF_DIS_BIT] = PF_DIS_O;
        main_word[`L2MC_EVICT_DIS_BIT] = EVICT_DIS_O;
        main_word[`L2MC_ECC_DIS_BIT] = ECC_DIS_O;
        main_word[`L2MC_DC_DIS_BIT] = DCACHE_DIS_O;
        main_word[`L2MC_TAG_SETUP_LSB +: `L2MC_LAT_W] = lat[0];
        main_word[`L2MC_TAG_READ_LSB +: `L2MC_LAT_W] = lat[1];
        main_word[`L2MC_TAG_WRITE_LSB +: `L2MC_LAT_W] = lat[2];
        main_word[`L2MC_DAT_SETUP_LSB +: `L2MC_LAT_W] = lat[3];
        main_word[`L2MC_DAT_READ_LSB +: `L2MC_LAT_W] = lat[4];
        main_word[`L2MC_DAT_WRITE_LSB +: `L2MC_LAT_W] = lat[5];
        ext_word = '0;
        ext_word[`L2MC_ECC_ERR_BIT] = ecc_flag;
        ext_word[`L2MC_AXI_ERR_BIT] = axi_flag;
        ext_word[`L2MC_SLEEP_MSB:`L2MC_SLEEP_LSB] = sleep_sel;
        ext_word[`L2MC_RET_MSB:`L2MC_RET_LSB] = ret_sel;
    end

    // ==========================================================
    // Access answer, one cycle after the request
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ACC_DONE_O    <= 1'b0;
            ACC_TRAP_O    <= 1'b0;
            ACC_TRAP_EL_O <= 2'h0;
            ACC_RDATA_O   <= 32'h0;
        end else begin
            ACC_DONE_O    <= ACC_VALID_I;
            ACC_TRAP_O    <= 1'b0;
            ACC_TRAP_EL_O <= 2'h0;
            ACC_RDATA_O   <= 32'h0;
            if (ACC_VALID_I) begin
                if ((ACC_WRITE_I && !permit) || (ACC_EL_I == l2mc_pkg::L2MC_EL0)) begin
                    ACC_TRAP_O    <= 1'b1;
                    ACC_TRAP_EL_O <= trap_level(ACC_EL_I, AUX_CONTROL_LEVEL2_I, NONSECURE_STATE_BIT_I);
                end else if (!ACC_WRITE_I) begin
                    ACC_RDATA_O   <= (ACC_SEL_I == l2mc_pkg::L2MC_SEL_EXT) ? ext_word : main_word;
                end
            end
        end
    end

    // ==========================================================
    // Low-power entry timers
    l2mc_idle_timer #(
        .WIDTH     (`L2MC_CNT_W)
    ) u_sleep_timer (
        .clk_i     (CORE_CLK_I),
        .nrst_i    (NRST_I),
        .idle_i    (RAM_IDLE_I),
        .step_i    (1'b1),
        .enable_i  (1'b1),
        .limit_i   (sleep_limit(sleep_sel)),
        .reached_o (LIGHT_SLEEP_O)
    );

    l2mc_idle_timer #(
        .WIDTH     (`L2MC_CNT_W)
    ) u_ret_timer (
        .clk_i     (CORE_CLK_I),
        .nrst_i    (NRST_I),
        .idle_i    (RAM_IDLE_I),
        .step_i    (TIMER_TICK_I),
        .enable_i  (ret_sel != 3'h0),
        .limit_i   (ret_limit(ret_sel)),
        .reached_o (RETENTION_O)
    );

    // ==========================================================
    // Assertions
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);

    a_trap_to_el3: assert property (
        ACC_VALID_I && ACC_WRITE_I && ACC_EL_I == l2mc_pkg::L2MC_EL1 && !AUX_CONTROL_LEVEL3_I
        && !(NONSECURE_STATE_BIT_I && !AUX_CONTROL_LEVEL2_I) |=> ACC_TRAP_O && ACC_TRAP_EL_O == 2'h3)
        else $error("refused write not trapped to EL3");

    a_trap_to_el2: assert property (
        ACC_VALID_I && ACC_WRITE_I && ACC_EL_I == l2mc_pkg::L2MC_EL1 && NONSECURE_STATE_BIT_I
        && !AUX_CONTROL_LEVEL2_I |=> ACC_TRAP_O && ACC_TRAP_EL_O == 2'h2)
        else $error("refused write not trapped to EL2");

    a_trap_no_store: assert property (
        ACC_VALID_I && ACC_WRITE_I && !permit |=> $stable(main_word[30:0]) && $stable(ret_sel))
        else $error("trapped write changed a register");

    a_core_count: assert property (
        ACC_DONE_O && !ACC_TRAP_O && $past(ACC_WRITE_I) == 1'b0 && $past(ACC_SEL_I) == 1'b0
        |-> ACC_RDATA_O[25:24] == CORE_CODE)
        else $error("core count read wrong");

    a_dc_dis_write: assert property (
        wr_main |=> DCACHE_DIS_O == $past(ACC_WDATA_I[18]) && ECC_DIS_O == $past(ACC_WDATA_I[19]))
        else $error("disable bits not written");

    a_lat_plus_one: assert property (
        wr_main |=> ##1 TAG_SETUP_CYC_O == {1'b0, $past(ACC_WDATA_I[17:15], 2)} + 4'h1)
        else $error("tag setup cycles not value plus one");

    a_ecc_sticky: assert property (
        ECC_DOUBLE_ERR_I |=> ecc_flag [*2] or (ecc_flag ##1 $past(clr_ecc)))
        else $error("ECC error flag lost");

    a_axi_clear: assert property (
        axi_flag && wr_ext && ACC_WDATA_I[29] && !AXI_ASYNC_ERR_I |=> axi_flag)
        else $error("write of one cleared async error");

    a_ext_live: assert property (
        wr_ext |=> ret_sel == $past(ACC_WDATA_I[2:0]) && sleep_sel == $past(ACC_WDATA_I[4:3]))
        else $error("extended write not applied");

    a_reserved_zero: assert property (
        ACC_DONE_O |-> ($past(ACC_SEL_I) ? (ACC_RDATA_O[31] == 1'b0 && ACC_RDATA_O[28:5] == 24'h0)
                                         : (ACC_RDATA_O[26] == 1'b0 && ACC_RDATA_O[23] == 1'b0)))
        else $error("reserved bit read non-zero");

    a_ret_off: assert property (
        ret_sel == 3'h0 |=> !RETENTION_O)
        else $error("retention entered while disabled");

    c_trap: cover property (ACC_TRAP_O);
    c_ecc_set: cover property (ECC_DOUBLE_ERR_I ##1 clr_ecc);
    c_sleep: cover property (sleep_sel == 2'h1 ##1 LIGHT_SLEEP_O);
    c_ret: cover property (RETENTION_O);

endmodule : l2mc_regs

// [verilog/l2mc_consts.svh]
`ifndef L2MC_CONSTS_SVH
`define L2MC_CONSTS_SVH

// ==========================================================
// Main control field positions
`define L2MC_RSTDIS_BIT      31
`define L2MC_FLUSH_MSB       30
`define L2MC_FLUSH_LSB       27
`define L2MC_CORES_MSB       25
`define L2MC_CORES_LSB       24
`define L2MC_PF_FULL_BIT     22
`define L2MC_PF_DIS_BIT      21
`define L2MC_EVICT_DIS_BIT   20
`define L2MC_ECC_DIS_BIT     19
`define L2MC_DC_DIS_BIT      18
`define L2MC_TAG_SETUP_LSB   15
`define L2MC_TAG_READ_LSB    12
`define L2MC_TAG_WRITE_LSB   9
`define L2MC_DAT_SETUP_LSB   6
`define L2MC_DAT_READ_LSB    3
`define L2MC_DAT_WRITE_LSB   0
`define L2MC_LAT_W           3

// ==========================================================
// Extended control field positions
`define L2MC_ECC_ERR_BIT     30
`define L2MC_AXI_ERR_BIT     29
`define L2MC_SLEEP_MSB       4
`define L2MC_SLEEP_LSB       3
`define L2MC_RET_MSB         2
`define L2MC_RET_LSB         0

// ==========================================================
// Reset values
`define L2MC_FLUSH_RST       4'h0
`define L2MC_BIT_RST         1'b0
`define L2MC_LAT_RST         3'h0
`define L2MC_SLEEP_RST       2'h0
`define L2MC_RET_RST         3'h0
`define L2MC_CYC_RST         4'h1

// ==========================================================
// Idle delay counts, in clock cycles or timer ticks
`define L2MC_CNT_W           10
`define L2MC_SLEEP_16        10'h010
`define L2MC_SLEEP_32        10'h020
`define L2MC_RET_2           10'h002
`define L2MC_RET_8           10'h008
`define L2MC_RET_32          10'h020
`define L2MC_RET_64          10'h040
`define L2MC_RET_128         10'h080
`define L2MC_RET_256         10'h100
`define L2MC_RET_512         10'h200

`endif

// [verilog/l2mc_pkg.sv]
package l2mc_pkg;

    typedef enum logic [1:0] {
        L2MC_EL0 = 2'b00,
        L2MC_EL1 = 2'b01,
        L2MC_EL2 = 2'b10,
        L2MC_EL3 = 2'b11
    } l2mc_el_t;

    typedef enum logic {
        L2MC_SEL_MAIN = 1'b0,
        L2MC_SEL_EXT  = 1'b1
    } l2mc_sel_t;

endpackage : l2mc_pkg

// [verilog/l2mc_idle_timer.sv]
`timescale 1ns/1ns
`include "l2mc_consts.svh"

module l2mc_idle_timer #(
    parameter int WIDTH = `L2MC_CNT_W
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             idle_i,
    input  wire logic             step_i,
    input  wire logic             enable_i,
    input  wire logic [WIDTH-1:0] limit_i,
    output logic                  reached_o
);

    logic [WIDTH-1:0] count;

    // ==========================================================
    // Idle step counter; any activity restarts the wait
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count <= '0;
        end else if (!idle_i || !enable_i) begin
            count <= '0;
        end else if (step_i && (count < limit_i)) begin
            count <= count + WIDTH'(1);
        end
    end

    // Limit is read live so a rewrite takes hold at once
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reached_o <= 1'b0;
        end else begin
            reached_o <= idle_i && enable_i && (count >= limit_i);
        end
    end

endmodule : l2mc_idle_timer

// [verif/tb.sv]
`timescale 1ns/1ns
module tb;
    logic        clk, nrst, valid, wr, sel, l3, l2, ns, rstdis, ecc_err, axi_err, idle, tick;
    logic        done, trap, pf_full, pf_dis, evict, ecc_dis, dc_dis, sleep, ret;
    logic [1:0]  el, trap_el, t;
    logic [3:0]  flush, tsu, trd, twr, dsu, drd, dwr;
    logic [31:0] wdata, rdata, mreg, ereg, d;
    logic [34:0] exp_q[$];
    int          n_errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          lim;

    l2mc_regs #(.NUM_CORES(4)) uut (
        .CORE_CLK_I(clk), .NRST_I(nrst), .ACC_VALID_I(valid), .ACC_WRITE_I(wr), .ACC_SEL_I(sel),
        .ACC_EL_I(el), .ACC_WDATA_I(wdata), .AUX_CONTROL_LEVEL3_I(l3), .AUX_CONTROL_LEVEL2_I(l2),
        .NONSECURE_STATE_BIT_I(ns), .RST_DISABLE_I(rstdis), .ECC_DOUBLE_ERR_I(ecc_err),
        .AXI_ASYNC_ERR_I(axi_err), .RAM_IDLE_I(idle), .TIMER_TICK_I(tick), .ACC_DONE_O(done),
        .ACC_RDATA_O(rdata), .ACC_TRAP_O(trap), .ACC_TRAP_EL_O(trap_el), .FLUSH_INC_O(flush),
        .PF_FULL_DIS_O(pf_full), .PF_DIS_O(pf_dis), .EVICT_DIS_O(evict), .ECC_DIS_O(ecc_dis),
        .DCACHE_DIS_O(dc_dis), .TAG_SETUP_CYC_O(tsu), .TAG_READ_CYC_O(trd), .TAG_WRITE_CYC_O(twr),
        .DAT_SETUP_CYC_O(dsu), .DAT_READ_CYC_O(drd), .DAT_WRITE_CYC_O(dwr), .LIGHT_SLEEP_O(sleep),
        .RETENTION_O(ret));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [34:0] g, input logic [34:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic stop_test;
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // ==========================================================
    // Expected answers, worked out from the register layout
    function automatic logic [31:0] main_word(input logic [31:0] v);
        return {1'b1, v[30:27], 1'b0, 2'b11, 1'b0, v[22:0]};
    endfunction : main_word

    function automatic logic [1:0] trap_of(input logic w, input logic [1:0] e);
        if (e == 2'h0) return 2'h1;
        if (e != 2'h1 || !w) return 2'h0;
        if (ns && !l2) return 2'h2;
        if (!l3) return 2'h3;
        return 2'h0;
    endfunction : trap_of

    // One access per call; callers chain them back to back
    task automatic op(input logic w, input logic s, input logic [1:0] e, input logic [31:0] v);
        @(negedge clk);
        t = trap_of(w, e);
        valid = 1'b1; wr = w; sel = s; el = e; wdata = v;
        exp_q.push_back({t != 2'h0, t, (w || t != 2'h0) ? 32'h0 : (s ? ereg : mreg)});
        if (w && t == 2'h0) begin
            if (s) ereg = {1'b0, ereg[30] & v[30], ereg[29] & v[29], 24'h0, v[4:0]};
            else mreg = main_word(v);
        end
    endtask : op

    task automatic quiet(input int n);
        @(negedge clk);
        valid = 1'b0;
        repeat (n) @(negedge clk);
    endtask : quiet

    task automatic tick_n(input int n);
        repeat (n) begin
            tick = 1'b1;
            @(negedge clk);
            tick = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask : tick_n

    // ==========================================================
    // Scoreboard: every answer is paired with the oldest note
    // Falling edge, well clear of the edge that launches the answer
    always @(negedge clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) chk(35'h0, 35'h1);
            else chk({trap, trap_el, rdata}, exp_q.pop_front());
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        {nrst, valid, wr, sel, ns, ecc_err, axi_err, idle, tick} = '0;
        {l3, l2, rstdis, el, wdata} = {3'b111, 2'h1, 32'h0};
        mreg = main_word(32'h0);
        ereg = 32'h0;
        void'($urandom(14));
        repeat (12) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        quiet(3);
        chk({flush, pf_full, pf_dis, evict, ecc_dis, dc_dis, sleep, ret}, 35'h0);
        chk({tsu, trd, twr, dsu, drd, dwr}, 35'h111111);
        op(1'b0, 1'b0, 2'h1, 32'h0);
        op(1'b0, 1'b1, 2'h2, 32'h0);
        quiet(2);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            d = $urandom;
            ns = i[0];
            // Single cluster bench, so data cache disable may be set
            op(1'b1, 1'b0, 2'h1, d);
            op(1'b0, 1'b0, 2'h3, 32'h0);
            quiet(2);
            chk({flush, pf_full, pf_dis, evict, ecc_dis, dc_dis}, {d[30:27], d[22:18]});
            chk({tsu, trd, twr}, {{1'b0, d[17:15]} + 4'h1, {1'b0, d[14:12]} + 4'h1, {1'b0, d[11:9]} + 4'h1});
            chk({dsu, drd, dwr}, {{1'b0, d[8:6]} + 4'h1, {1'b0, d[5:3]} + 4'h1, {1'b0, d[2:0]} + 4'h1});
        end
        $display("test main fields done");
        for (int c = 0; c < 32; c++) begin
            {l3, l2, ns} = c[2:0];
            op(1'b1, c[3], c[1:0] ^ {1'b0, c[4]}, $urandom & 32'h9fff_ffe7);
            op(1'b0, c[3], 2'h1, 32'h0);
            op(1'b0, c[3], 2'h0, 32'h0);
        end
        quiet(1);
        {l3, l2} = 2'b11;
        $display("test access rights done");
        ecc_err = 1'b1;
        @(negedge clk);
        ecc_err = 1'b0;
        axi_err = 1'b1;
        @(negedge clk);
        axi_err = 1'b0;
        ereg[30:29] = 2'b11;
        op(1'b0, 1'b1, 2'h1, 32'h0);
        op(1'b1, 1'b1, 2'h1, 32'h4000_0000);
        op(1'b0, 1'b1, 2'h1, 32'h0);
        op(1'b1, 1'b1, 2'h1, 32'h6000_0000);
        op(1'b0, 1'b1, 2'h2, 32'h0);
        op(1'b1, 1'b1, 2'h1, 32'h0);
        op(1'b0, 1'b1, 2'h1, 32'h0);
        // Error in the same cycle as a clearing write: set wins
        ecc_err = 1'b1;
        op(1'b1, 1'b1, 2'h1, 32'h0);
        ereg[30] = 1'b1;
        op(1'b0, 1'b1, 2'h1, 32'h0);
        ecc_err = 1'b0;
        quiet(1);
        $display("test error flags done");
        for (int s = 0; s < 4; s++) begin
            lim = (s == 0) ? 0 : ((s == 1) ? 16 : 32);
            op(1'b1, 1'b1, 2'h1, s << 3);
            quiet(2);
            idle = 1'b1;
            if (lim > 0) begin
                repeat (lim - 4) @(negedge clk);
                chk(sleep, 1'b0);
            end
            repeat (8) @(negedge clk);
            chk(sleep, 1'b1);
            idle = 1'b0;
            repeat (3) @(negedge clk);
            chk(sleep, 1'b0);
        end
        for (int r = 0; r < 8; r++) begin
            lim = (r == 0) ? 40 : ((r == 1) ? 2 : ((r == 2) ? 8 : (32 << (r - 3))));
            op(1'b1, 1'b1, 2'h1, r);
            quiet(2);
            idle = 1'b1;
            tick_n(lim - 1);
            chk(ret, 1'b0);
            tick_n(3);
            chk(ret, r != 0);
            idle = 1'b0;
            repeat (3) @(negedge clk);
        end
        $display("test idle timers done");
        chk(exp_q.size(), 35'h0);
        stop_test();
    end
endmodule : tb
